//--- pkg/pcdp_pkg.sv
// Purpose: shared constants and types of the loop control block
// Assumes: 125 MHz fabric clock, 32-bit classic wishbone register bus
// Notes:   byte addresses are word aligned
package pcdp_pkg;
    // timing
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned LOSS_NS      = 1000;
    localparam int unsigned LOSS_CYC     = LOSS_NS * CLK_MHZ / 1000;
    localparam int unsigned LOCK_GOOD_N  = 8;

    // phase wheel of the internal oscillator
    localparam int unsigned PH_W         = 4;
    localparam logic [3:0]  PH_HALF      = 4'h8;

    // register offsets
    localparam int unsigned ADR_W        = 8;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_KDIV     = 8'h04;
    localparam logic [7:0]  REG_STAT     = 8'h08;
    localparam logic [7:0]  REG_ISTAT    = 8'h0c;
    localparam logic [7:0]  REG_ICLR     = 8'h10;
    localparam logic [7:0]  REG_IEN      = 8'h14;

    // control register fields
    localparam int unsigned CTRL_FB_LSB  = 0;
    localparam int unsigned CTRL_DEL_LSB = 4;
    localparam int unsigned CTRL_LEAD    = 7;
    localparam int unsigned CTRL_PH_LSB  = 8;
    localparam int unsigned CTRL_DTY_LSB = 12;
    localparam logic [31:0] CTRL_RST     = 32'h0000_8000;
    localparam logic [31:0] CTRL_MASK    = 32'h0000_fff3;

    // feedback sources
    localparam logic [1:0]  FB_INT       = 2'h0;
    localparam logic [1:0]  FB_NET       = 2'h1;

    // secondary divider
    localparam int unsigned KDIV_W       = 8;
    localparam logic [7:0]  KDIV_RST     = 8'h02;

    // status and interrupt fields
    localparam int unsigned STAT_LOCK    = 0;
    localparam int unsigned STAT_ST_LSB  = 1;
    localparam int unsigned STAT_AP_LSB  = 4;
    localparam int unsigned IRQ_W        = 2;
    localparam int unsigned IRQ_ACQ      = 0;
    localparam int unsigned IRQ_LOST     = 1;

    typedef enum logic [1:0] {
        PCDP_UNLOCKED,
        PCDP_ACQUIRE,
        PCDP_LOCKED
    } pcdp_lock_t;
endpackage

//--- verilog/pcdp_kdiv.sv
// Purpose: secondary divider, one output toggle per i_div input edges
// Assumes: i_tick marks each edge of the undivided clock
// Notes:   a divisor of zero acts as one
`timescale 1ns/1ps
module pcdp_kdiv #(
    parameter int unsigned W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_clr,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_div,
    output logic              o_clk
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         clk;
    } pcdp_kdiv_t;

    pcdp_kdiv_t q_r;
    pcdp_kdiv_t q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (i_clr) begin
            q_nxt = '0;
        end else if (i_tick) begin
            if (i_div == '0 || q_r.cnt >= i_div - W'(1)) begin
                q_nxt.cnt = '0;
                q_nxt.clk = ~q_r.clk;
            end else begin
                q_nxt.cnt = q_r.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_clk = q_r.clk;

    clr_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_clr |=> (!o_clk && q_r.cnt == '0))
        else $error("divider not held by its reset");
endmodule

//--- verilog/pcdp_loop.sv
// Purpose: control and status of a phase-locked loop with delay, phase and duty control
// Assumes: all pins synchronous to i_clk; oscillator modelled as a phase wheel on i_clk
// Notes:   GENERAL_LOOP=0 gives the standard variant without delay control
`timescale 1ns/1ps
module pcdp_loop #(
    parameter bit          GENERAL_LOOP = 1'b1,
    parameter int unsigned LOCK_N       = pcdp_pkg::LOCK_GOOD_N,
    parameter int unsigned LOSS_CYC     = pcdp_pkg::LOSS_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ref_clk_in,
    input  wire logic        i_feedback_clk_in,
    input  wire logic        i_main_reset,
    input  wire logic        i_secondary_div_reset,
    input  wire logic        i_delay_source_select,
    input  wire logic        i_delay_zero_force,
    input  wire logic        i_delay_lead_lag_select,
    input  wire logic [2:0]  i_delay_amount,
    input  wire logic        i_phase_duty_adjust_mode,
    input  wire logic [3:0]  i_phase_adjust_sel,
    input  wire logic [3:0]  i_duty_cycle_sel,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_primary_clk_out,
    output logic             o_shifted_clk_out,
    output logic             o_divided_clk_out,
    output logic             o_lock,
    output logic             o_irq
);
    localparam int unsigned GW = $clog2(LOCK_N + 1);
    localparam int unsigned TW = $clog2(LOSS_CYC + 1);
    localparam int unsigned PW = pcdp_pkg::PH_W;

    typedef struct packed {
        pcdp_pkg::pcdp_lock_t  st;
        logic [PW-1:0]         ph;
        logic                  prim;
        logic                  shft;
        logic                  net;
        logic                  ref_q;
        logic                  fb_q;
        logic [1:0]            fb_seen;
        logic [GW-1:0]         good;
        logic [TW-1:0]         wdog;
        logic                  lock;
        logic [PW-1:0]         apply;
        logic [31:0]           ctrl;
        logic [pcdp_pkg::KDIV_W-1:0] kdiv;
        logic [pcdp_pkg::IRQ_W-1:0]  ist;
        logic [pcdp_pkg::IRQ_W-1:0]  ien;
        logic                  ack;
        logic [31:0]           dat;
        logic                  irq;
    } pcdp_state_t;

    pcdp_state_t q_r;
    pcdp_state_t q_nxt;

    logic       div_clk;
    logic       prim_tick;
    logic       fb_now;
    logic       fb_edge;
    logic       ref_edge;
    logic       win_good;
    logic [2:0] del_amt;
    logic       del_lead;
    logic [3:0] ph_sel;
    logic [3:0] dty_sel;
    logic [3:0] shift;
    logic [3:0] pos;
    logic [pcdp_pkg::IRQ_W-1:0] ev;
    logic       wr;
    logic [31:0] rd;

    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        q_nxt = q_r;
        ev    = '0;
        // feedback source
        case (q_r.ctrl[pcdp_pkg::CTRL_FB_LSB +: 2])
            pcdp_pkg::FB_INT: fb_now = q_r.prim;
            pcdp_pkg::FB_NET: fb_now = q_r.net;
            default:          fb_now = i_feedback_clk_in;
        endcase
        fb_edge  = fb_now & ~q_r.fb_q;
        ref_edge = i_ref_clk_in & ~q_r.ref_q;
        // delay source and value
        if (i_delay_source_select) begin
            del_amt  = i_delay_amount;
            del_lead = i_delay_lead_lag_select;
        end else begin
            del_amt  = q_r.ctrl[pcdp_pkg::CTRL_DEL_LSB +: 3];
            del_lead = q_r.ctrl[pcdp_pkg::CTRL_LEAD];
        end
        if (!GENERAL_LOOP || i_delay_zero_force) begin
            q_nxt.apply = '0;
        end else if (del_lead) begin
            q_nxt.apply = PW'(4'h0 - {1'b0, del_amt});
        end else begin
            q_nxt.apply = {1'b0, del_amt};
        end
        // phase and duty source
        if (i_phase_duty_adjust_mode) begin
            ph_sel  = i_phase_adjust_sel;
            dty_sel = i_duty_cycle_sel;
        end else begin
            ph_sel  = q_r.ctrl[pcdp_pkg::CTRL_PH_LSB +: 4];
            dty_sel = q_r.ctrl[pcdp_pkg::CTRL_DTY_LSB +: 4];
        end
        shift = PW'(ph_sel + q_r.apply);
        // oscillator wheel and outputs
        q_nxt.ph   = PW'(q_r.ph + PW'(1));
        // outputs follow the current wheel step so the first high phase after reset is full
        q_nxt.prim = (q_r.ph < pcdp_pkg::PH_HALF);
        pos        = PW'(q_r.ph - shift);
        q_nxt.shft = (pos < dty_sel);
        q_nxt.net  = q_r.prim;
        q_nxt.fb_q = fb_now;
        q_nxt.ref_q = i_ref_clk_in;
        // lock detector: one feedback edge per reference period
        win_good = (q_r.fb_seen == 2'h0) ? fb_edge : (q_r.fb_seen == 2'h1) && !fb_edge;
        if (ref_edge) begin
            q_nxt.fb_seen = 2'h0;
            q_nxt.wdog    = '0;
        end else begin
            if (fb_edge && q_r.fb_seen != 2'h2) begin
                q_nxt.fb_seen = q_r.fb_seen + 2'h1;
            end
            if (q_r.wdog != TW'(LOSS_CYC)) begin
                q_nxt.wdog = TW'(q_r.wdog + TW'(1));
            end
        end
        case (q_r.st)
            pcdp_pkg::PCDP_UNLOCKED: begin
                q_nxt.good = '0;
                if (ref_edge && win_good) begin
                    q_nxt.st   = pcdp_pkg::PCDP_ACQUIRE;
                    q_nxt.good = GW'(1);
                end
            end
            pcdp_pkg::PCDP_ACQUIRE: begin
                if (q_r.wdog == TW'(LOSS_CYC) || (ref_edge && !win_good)) begin
                    q_nxt.st = pcdp_pkg::PCDP_UNLOCKED;
                end else if (ref_edge) begin
                    q_nxt.good = GW'(q_r.good + GW'(1));
                    if (q_r.good == GW'(LOCK_N - 1)) begin
                        q_nxt.st = pcdp_pkg::PCDP_LOCKED;
                        ev[pcdp_pkg::IRQ_ACQ] = 1'b1;
                    end
                end
            end
            pcdp_pkg::PCDP_LOCKED: begin
                if (q_r.wdog == TW'(LOSS_CYC) || (ref_edge && !win_good)) begin
                    q_nxt.st = pcdp_pkg::PCDP_UNLOCKED;
                    ev[pcdp_pkg::IRQ_LOST] = 1'b1;
                end
            end
            default: q_nxt.st = pcdp_pkg::PCDP_UNLOCKED;
        endcase
        q_nxt.lock = (q_nxt.st == pcdp_pkg::PCDP_LOCKED);
        // main reset holds the loop
        if (i_main_reset) begin
            q_nxt.ph      = '0;
            q_nxt.prim    = 1'b0;
            q_nxt.shft    = 1'b0;
            q_nxt.net     = 1'b0;
            q_nxt.fb_q    = 1'b0;
            q_nxt.fb_seen = '0;
            q_nxt.good    = '0;
            q_nxt.wdog    = '0;
            q_nxt.st      = pcdp_pkg::PCDP_UNLOCKED;
            q_nxt.lock    = 1'b0;
            ev            = '0;
        end
        // register bus
        wr = i_wb_cyc && i_wb_stb && i_wb_we && q_r.ack;
        case (i_wb_adr)
            pcdp_pkg::REG_CTRL:  rd = q_r.ctrl;
            pcdp_pkg::REG_KDIV:  rd = 32'(q_r.kdiv);
            pcdp_pkg::REG_STAT:  begin
                rd = '0;
                rd[pcdp_pkg::STAT_LOCK] = q_r.lock;
                rd[pcdp_pkg::STAT_ST_LSB +: 2] = q_r.st;
                rd[pcdp_pkg::STAT_AP_LSB +: PW] = q_r.apply;
            end
            pcdp_pkg::REG_ISTAT: rd = 32'(q_r.ist);
            pcdp_pkg::REG_IEN:   rd = 32'(q_r.ien);
            default:             rd = '0;
        endcase
        q_nxt.ack = i_wb_cyc && i_wb_stb && !q_r.ack;
        q_nxt.dat = q_nxt.ack ? rd : '0;
        if (wr && i_wb_adr == pcdp_pkg::REG_CTRL) begin
            q_nxt.ctrl = lanes(q_r.ctrl, i_wb_dat, i_wb_sel) & pcdp_pkg::CTRL_MASK;
        end
        if (wr && i_wb_adr == pcdp_pkg::REG_KDIV && i_wb_sel[0]) begin
            q_nxt.kdiv = i_wb_dat[pcdp_pkg::KDIV_W-1:0];
        end
        if (wr && i_wb_adr == pcdp_pkg::REG_IEN && i_wb_sel[0]) begin
            q_nxt.ien = i_wb_dat[pcdp_pkg::IRQ_W-1:0];
        end
        // clear then set: an event in the clearing cycle survives
        if (wr && i_wb_adr == pcdp_pkg::REG_ICLR && i_wb_sel[0]) begin
            q_nxt.ist = q_r.ist & ~i_wb_dat[pcdp_pkg::IRQ_W-1:0];
        end
        q_nxt.ist = q_nxt.ist | ev;
        q_nxt.irq = |(q_nxt.ist & q_nxt.ien);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q_r      <= '0;
            q_r.st   <= pcdp_pkg::PCDP_UNLOCKED;
            q_r.ctrl <= pcdp_pkg::CTRL_RST;
            q_r.kdiv <= pcdp_pkg::KDIV_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign prim_tick = q_r.prim ^ q_nxt.prim;

    pcdp_kdiv #(
        .W      (pcdp_pkg::KDIV_W)
    ) u_kdiv (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_clr  (i_secondary_div_reset | i_main_reset),
        .i_tick (prim_tick),
        .i_div  (q_r.kdiv),
        .o_clk  (div_clk)
    );

    assign o_primary_clk_out = q_r.prim;
    assign o_shifted_clk_out = q_r.shft;
    assign o_divided_clk_out = div_clk;
    assign o_lock            = q_r.lock;
    assign o_irq             = q_r.irq;
    assign o_wb_ack          = q_r.ack;
    assign o_wb_dat          = q_r.dat;

    default clocking dc @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence prim_high_s;
        o_primary_clk_out [*8];
    endsequence

    reset_hold_a: assert property (i_main_reset |=> (q_r.ph == '0 && !o_primary_clk_out))
        else $error("loop not held in reset");
    div_reset_a: assert property (i_secondary_div_reset |=> !o_divided_clk_out)
        else $error("divided clock not cleared");
    lock_rise_a: assert property ($rose(o_lock) |-> $past(q_r.st) == pcdp_pkg::PCDP_ACQUIRE)
        else $error("lock rose without acquisition");
    lock_reset_a: assert property (i_main_reset |=> !o_lock [*2])
        else $error("lock high during reset");
    prim_wave_a: assert property (disable iff (!i_nrst || i_main_reset)
        $rose(o_primary_clk_out) |-> prim_high_s ##1 !o_primary_clk_out)
        else $error("primary clock duty wrong");
    duty_zero_a: assert property ((i_phase_duty_adjust_mode && i_duty_cycle_sel == 4'h0)
        |=> !o_shifted_clk_out)
        else $error("zero duty still high");
    div_src_a: assert property ($changed(o_divided_clk_out) && !$past(i_secondary_div_reset)
        && !$past(i_main_reset) |-> $past(prim_tick))
        else $error("divided clock moved off a primary edge");
    zero_force_a: assert property (i_delay_zero_force |=> q_r.apply == '0)
        else $error("delay not forced to zero");
    lead_sign_a: assert property ((GENERAL_LOOP && i_delay_source_select && !i_delay_zero_force
        && i_delay_lead_lag_select) |=> q_r.apply == PW'(4'h0 - {1'b0, $past(i_delay_amount)}))
        else $error("lead delay sign wrong");
    std_nodelay_a: assert property (!GENERAL_LOOP |-> q_r.apply == '0)
        else $error("standard variant applied delay");
    ack_drop_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
endmodule

//--- sim/pcdp_ref_src.sv
// Purpose: reference clock source and user feedback pin on the far side of the loop
// Assumes: reference period of 16 fabric cycles, clock stands low while idle
// Notes:   i_bad_fb doubles the feedback rate to break lock on purpose
`timescale 1ns/1ps
module pcdp_ref_src (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_run,
    input  wire logic i_bad_fb,
    output logic      o_ref_clk,
    output logic      o_fb_clk
);
    logic [3:0] cnt_r;

    always_ff @(posedge i_clk) begin
        if (!i_nrst || !i_run) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    assign o_ref_clk = i_run && cnt_r[3];
    // user feedback pin follows the reference unless told to misbehave
    assign o_fb_clk  = i_bad_fb ? cnt_r[2] : o_ref_clk;
endmodule

//--- sim/pcdp_loop_tb.sv
// Purpose: self-checking bench of the loop control block
// Assumes: short lock and loss counts set through parameters
// Notes:   register reads are checked by a queue-driven monitor
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error at %0t: value %h expected %h", $time, (got), (exp)); end end
module pcdp_loop_tb;
    localparam int unsigned LOCK_N = 2;
    localparam int unsigned LOSS_N = 40;
    logic        i_clk, i_nrst, main_rst, div_rst, dsrc, dzero, dlead, pmode, run, bad_fb;
    logic [2:0]  damt, ra;
    logic [3:0]  ph_sel, dty_sel, wb_sel, rph, rdt;
    logic        cyc, stb, we, ack, prim, shft, divd, lock, irq, ref_clk, fb_clk;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, e;
    logic [31:0] exp_q[$];
    logic        prim_q, shft_q, divd_q, shft2, shft2_q;
    int          mismatches, n_compared, seed, cnt, p_rise, p_per, s_rise, d_tog, d_half;
    int          s2_rise;

    pcdp_loop #(.LOCK_N(LOCK_N), .LOSS_CYC(LOSS_N)) dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ref_clk_in(ref_clk), .i_feedback_clk_in(fb_clk),
        .i_main_reset(main_rst), .i_secondary_div_reset(div_rst),
        .i_delay_source_select(dsrc), .i_delay_zero_force(dzero),
        .i_delay_lead_lag_select(dlead), .i_delay_amount(damt),
        .i_phase_duty_adjust_mode(pmode), .i_phase_adjust_sel(ph_sel),
        .i_duty_cycle_sel(dty_sel), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(wb_sel), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_primary_clk_out(prim), .o_shifted_clk_out(shft), .o_divided_clk_out(divd),
        .o_lock(lock), .o_irq(irq));

    // standard variant on the same pins: delay inputs must not move its shifted clock
    pcdp_loop #(.GENERAL_LOOP(1'b0), .LOCK_N(LOCK_N), .LOSS_CYC(LOSS_N)) dut_std (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ref_clk_in(ref_clk), .i_feedback_clk_in(fb_clk),
        .i_main_reset(main_rst), .i_secondary_div_reset(div_rst),
        .i_delay_source_select(dsrc), .i_delay_zero_force(dzero),
        .i_delay_lead_lag_select(dlead), .i_delay_amount(damt),
        .i_phase_duty_adjust_mode(pmode), .i_phase_adjust_sel(ph_sel),
        .i_duty_cycle_sel(dty_sel), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(wb_sel), .o_wb_dat(), .o_wb_ack(),
        .o_primary_clk_out(), .o_shifted_clk_out(shft2), .o_divided_clk_out(),
        .o_lock(), .o_irq());

    pcdp_ref_src partner (.i_clk(i_clk), .i_nrst(i_nrst), .i_run(run), .i_bad_fb(bad_fb),
        .o_ref_clk(ref_clk), .o_fb_clk(fb_clk));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic give_verdict();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; wb_sel <= 4'hf;
        @(posedge i_clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 50) begin
            mismatches++;
            $display("Error at %0t: no bus answer", $time);
        end
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic wait_lock(input logic v, input int lim);
        int n;
        n = 0;
        while (lock !== v && n < lim) begin
            @(posedge i_clk);
            n++;
        end
        `CHK(lock, v)
    endtask

    // settle, then count shifted high time and its offset from the primary rise
    task automatic shift_chk(input int off, input int duty);
        int h;
        h = 0;
        repeat (48) @(posedge i_clk);
        for (int i = 0; i < 16; i++) begin
            @(posedge i_clk);
            if (shft === 1'b1) h++;
        end
        `CHK(h, duty)
        `CHK((((s_rise - p_rise - off) % 16) + 16) % 16, 0)
    endtask

    always @(posedge i_clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            e = exp_q.pop_front();
            `CHK(rdat, e)
        end
    end

    always @(posedge i_clk) begin
        cnt <= cnt + 1;
        prim_q <= prim;
        shft_q <= shft;
        divd_q <= divd;
        if (prim === 1'b1 && prim_q === 1'b0) begin
            p_per <= cnt - p_rise;
            p_rise <= cnt;
        end
        if (shft === 1'b1 && shft_q === 1'b0) s_rise <= cnt;
        shft2_q <= shft2;
        if (shft2 === 1'b1 && shft2_q === 1'b0) s2_rise <= cnt;
        if (divd !== divd_q) begin
            d_half <= cnt - d_tog;
            d_tog <= cnt;
        end
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        {i_nrst, main_rst, div_rst, dsrc, dzero, dlead, pmode, run, bad_fb} = '0;
        {cyc, stb, we, damt, ph_sel, dty_sel, wb_sel, adr, wdat} = '0;
        {prim_q, shft_q, divd_q, shft2_q} = '0;
        s2_rise = 0;
        {mismatches, n_compared, cnt, p_rise, p_per, s_rise, d_tog, d_half} = '0;
        seed = 91587;
        repeat (16) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        rd(pcdp_pkg::REG_CTRL, pcdp_pkg::CTRL_RST);
        rd(pcdp_pkg::REG_KDIV, 32'h0000_0002);
        rd(8'h20, 32'h0000_0000);
        rd(pcdp_pkg::REG_ICLR, 32'h0000_0000);
        bus(pcdp_pkg::REG_IEN, 1'b1, 32'h0000_0001);
        bus(pcdp_pkg::REG_CTRL, 1'b1, 32'h0000_8002);
        run <= 1'b1;
        wait_lock(1'b1, 300);
        `CHK(irq, 1'b1)
        rd(pcdp_pkg::REG_ISTAT, 32'h0000_0001);
        bus(pcdp_pkg::REG_ICLR, 1'b1, 32'h0000_0001);
        @(posedge i_clk);
        `CHK(irq, 1'b0)
        `CHK(p_per, 16)
        for (int k = 0; k < 3; k++) begin
            rph = $random(seed);
            rdt = 4'h1 + 4'({$random(seed)} % 15);
            ra = $random(seed);
            pmode <= 1'b1; dsrc <= 1'b1; ph_sel <= rph; dty_sel <= rdt; damt <= ra;
            dzero <= (k == 0); dlead <= (k == 2);
            shift_chk(k == 0 ? int'(rph) : k == 1 ? rph + ra : rph - ra, rdt);
            `CHK((((s2_rise - p_rise - int'(rph)) % 16) + 16) % 16, 0)
        end
        pmode <= 1'b0; dsrc <= 1'b0;
        bus(pcdp_pkg::REG_CTRL, 1'b1, 32'h0000_5232);
        shift_chk(5, 5);
        bus(pcdp_pkg::REG_KDIV, 1'b1, 32'h0000_0003);
        repeat (100) @(posedge i_clk);
        `CHK(d_half, 24)
        div_rst <= 1'b1;
        repeat (40) @(posedge i_clk);
        `CHK(divd, 1'b0)
        `CHK(lock, 1'b1)
        `CHK(p_per, 16)
        div_rst <= 1'b0;
        bad_fb <= 1'b1;
        wait_lock(1'b0, 100);
        rd(pcdp_pkg::REG_ISTAT, 32'h0000_0002);
        bad_fb <= 1'b0;
        wait_lock(1'b1, 300);
        main_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        `CHK(lock, 1'b0)
        repeat (30) @(posedge i_clk);
        `CHK({prim, shft, divd}, 3'h0)
        main_rst <= 1'b0;
        repeat (16) @(posedge i_clk);
        `CHK(lock, 1'b0)
        wait_lock(1'b1, 300);
        for (int s = 0; s < 2; s++) begin
            run <= 1'b0;
            wait_lock(1'b0, LOSS_N + 40);
            bus(pcdp_pkg::REG_CTRL, 1'b1, 32'h0000_8000 | s);
            run <= 1'b1;
            wait_lock(1'b1, 300);
        end
        give_verdict();
    end
endmodule
